// ### design/osd_pkg.sv
// Shared constants and carrier types for the strip display engine.
// Assumes a single pixel clock domain and an APB register port.
package osd_pkg;
	// Register map
	localparam logic [12:0] OFF_CTRL = 13'h0000;
	localparam logic [12:0] OFF_LINE = 13'h0004;
	localparam logic [12:0] OFF_DELAY = 13'h0008;
	localparam logic [12:0] OFF_HEIGHT = 13'h000c;
	localparam logic [12:0] OFF_STATUS = 13'h0010;
	localparam int RAM_WIN_BIT = 12;
	localparam int CTRL_PAGE_LSB = 0;
	localparam int CTRL_PAGE_MSB = 3;
	localparam int CTRL_BLANK_BIT = 4;
	// Reset values
	localparam logic [3:0] RST_PAGE = 4'h0;
	localparam logic RST_BLANK = 1'b0;
	localparam logic [6:0] RST_LINE = 7'h40;
	localparam logic [7:0] RST_DELAY = 8'h10;
	localparam logic [5:0] RST_HEIGHT = 6'h12;
	// Horizontal geometry
	localparam logic [10:0] GLYPH_W = 11'h00c;
	localparam logic [10:0] MARGIN_EVEN = 11'h036;
	localparam logic [10:0] MARGIN_ODD = 11'h03c;
	localparam logic [10:0] DELAY_STEP = 11'h006;
	localparam logic [10:0] DELAY_BIAS = 11'h006;
	localparam logic [7:0] DELAY_FLOOR_MAX = 8'h07;
	// Vertical geometry
	localparam logic [4:0] LAST_SLICE = 5'h11;
	localparam logic [6:0] SLICES_PER_GLYPH = 7'h12;
	// Display RAM layout
	localparam logic [9:0] PAGE_STRIDE = 10'h040;
	localparam logic [9:0] UDC_STRIDE = 10'h040;
	localparam logic [9:0] SLICE_BIAS = 10'h007;
	localparam logic [9:0] SLICE_BYTES = 10'h002;
	localparam logic [9:0] DESC_BYTES = 10'h002;
	// Code classes
	localparam logic [7:0] UDC_FIRST = 8'hf0;
	localparam logic [7:0] UDC_LAST = 8'hfe;
	localparam logic [7:0] END_OF_ROW_CODE = 8'h0f;
	localparam logic [7:0] COLOUR_FIRST = 8'h10;
	localparam logic [7:0] COLOUR_LAST = 8'h17;
	localparam logic [7:0] ROM_FIRST = 8'h20;
	localparam logic [7:0] ROM_LAST = 8'hdf;
	localparam logic [7:0] ROM_HIGH_FIRST = 8'hf0;

	typedef struct packed {
		logic [3:0] page;
		logic blank_level_bit;
		logic [6:0] line_length_setting;
		logic [7:0] horizontal_delay_setting;
		logic [5:0] glyph_height_lines;
	} cfg_t;

	typedef struct packed {
		logic en;
		logic [9:0] addr;
		logic [7:0] data;
	} ram_wr_t;
endpackage

// ### design/osd_sync3.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous level input and the engine's clock enable.
`timescale 1ns/1ps
module osd_sync3 (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic pin,
	output logic level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} sync_t;
	sync_t s;
	sync_t next_s;

	always_comb begin
		next_s = s;
		next_s.s1 = pin;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		// Only a level seen twice in a row is accepted
		if (s.s2 == s.s3) begin
			next_s.lvl = s.s3;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign level = s.lvl;
endmodule

// ### design/osd_ram.sv
// 1-kbyte display RAM: one write port, one registered read port.
// Assumes the writer and the reader share the engine clock.
`timescale 1ns/1ps
module osd_ram (
	input wire logic clk,
	input wire logic ce,
	input wire osd_pkg::ram_wr_t wr,
	input wire logic [9:0] rd_addr,
	output logic [7:0] rd_data
);
	logic [7:0] mem [1024];

	// Contents are undefined until software loads them
	always_ff @(posedge clk) begin
		if (ce) begin
			if (wr.en) begin
				mem[wr.addr] <= wr.data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// ### design/osd_engine.sv
// Strip display engine: descriptor walk, glyph fetch and pixel output.
// Assumes CLK is the pixel clock already locked to line sync, a glyph
// store that answers ROM_BITS combinationally, and an APB master.
//
// What this block does, except RULE7, a limit on the reference clock
// [RULE1] Codes 240-254 take shape from RAM
// [RULE2] User glyph is 12 pixels by 18 slices
// [RULE3] Set bit foreground, clear bit background
// [RULE4] Slice is even low byte, odd high nibble
// [RULE5] Bit 11 leftmost, bit 0 rightmost
// [RULE6] Slice address 64*(code-240)+2*(slice+7)
// [RULE7] Reference clock between 6 and 15 MHz
// [RULE8] Line is 12*(2*setting[6:1]+1) pixels
// [RULE9] Left margin 6*(delay-6)+54 pixels
// [RULE10] Margin floor 54 even, 60 odd
// [RULE11] Screen built of strips, 16 table pages
// [RULE12] Spacing lines black or transparent by level
// [RULE13] Character strip reads codes from its address
// [RULE14] Vertical sync restarts at selected page top
// [RULE15] Character strip lasts glyph height lines
// [RULE16] Finished strip fetches next descriptor
// [RULE17] Top bit 0: spacing, unit bit, count
// [RULE18] Top bit 1: show, colour, address, enable
// [RULE19] Hidden strip: colour zero, blank follows level
// [RULE20] Code 15 ends the row for the line
// [RULE21] All fetch logic on the pixel clock
// [RULE22] Reset idles engine with outputs inactive
`timescale 1ns/1ps
module osd_engine (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic CE,
	input wire logic HSYNC,
	input wire logic VSYNC,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [12:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic [7:0] ROM_CODE,
	output logic [4:0] ROM_SLICE,
	input wire logic [11:0] ROM_BITS,
	output logic [3:0] COLOR,
	output logic FAST_BLANK_OUTPUT
);
	typedef enum logic [3:0] {
		S_IDLE, S_DESC_HI, S_DESC_LO, S_DESC_DONE, S_HOLD, S_SLICE, S_CODE,
		S_CODE_WAIT, S_ROM, S_GLYPH_LO, S_GLYPH_HI, S_GLYPH_DONE, S_CELL_WAIT, S_ROW_END
	} fsm_t;

	typedef struct packed {
		fsm_t st;
		osd_pkg::cfg_t cfg;
		logic [9:0] ptr;
		logic [7:0] dhi;
		logic [7:0] dlo;
		logic first;
		logic inl;
		logic [13:0] left;
		logic [4:0] slice;
		logic [6:0] acc;
		logic [9:0] cptr;
		logic [3:0] colour;
		logic [7:0] code;
		logic [7:0] udc_lo;
		logic [11:0] glyph;
		logic [11:0] shape;
		logic showing;
		logic [10:0] px;
		logic [10:0] cell_next;
		logic hs_d;
		logic vs_d;
		logic [3:0] col_out;
		logic fb;
		logic [31:0] prdata;
		logic pslverr;
	} core_t;

	core_t s;
	core_t n;
	logic hs_lvl;
	logic vs_lvl;
	logic hs_rise;
	logic vs_rise;
	logic line_start;
	logic boundary;
	logic load;
	logic go_line;
	logic [11:0] shape_now;
	logic [10:0] line_len;
	logic [10:0] margin;
	logic [5:0] h_eff;
	logic [9:0] udc_addr;
	logic [9:0] ram_rd_addr;
	logic [7:0] ram_rd;
	osd_pkg::ram_wr_t ram_wr;

	osd_sync3 u_hsync (.clk(CLK), .nrst(NRST), .ce(CE), .pin(HSYNC), .level(hs_lvl));
	osd_sync3 u_vsync (.clk(CLK), .nrst(NRST), .ce(CE), .pin(VSYNC), .level(vs_lvl));
	osd_ram u_ram (.clk(CLK), .ce(CE), .wr(ram_wr), .rd_addr(ram_rd_addr), .rd_data(ram_rd));

	////////////////////////////////////////////////////////////////////////////////
	// Geometry
	always_comb begin
		line_len = osd_pkg::GLYPH_W * 11'({s.cfg.line_length_setting[6:1], 1'b1}); // RULE8
		if (s.cfg.horizontal_delay_setting <= osd_pkg::DELAY_FLOOR_MAX) begin
			margin = s.cfg.horizontal_delay_setting[0] ? osd_pkg::MARGIN_ODD
				: osd_pkg::MARGIN_EVEN; // RULE10
		end else begin
			margin = osd_pkg::DELAY_STEP * (11'(s.cfg.horizontal_delay_setting)
				- osd_pkg::DELAY_BIAS) + osd_pkg::MARGIN_EVEN; // RULE9
		end
		// Zero height would stall the slice stepper
		h_eff = (s.cfg.glyph_height_lines == 6'h00) ? 6'h01 : s.cfg.glyph_height_lines;
		udc_addr = osd_pkg::UDC_STRIDE * 10'(s.code - osd_pkg::UDC_FIRST)
			+ (10'(s.slice) + osd_pkg::SLICE_BIAS) * osd_pkg::SLICE_BYTES; // RULE6
		unique case (s.st)
			S_DESC_HI: ram_rd_addr = s.ptr;
			S_DESC_LO: ram_rd_addr = s.ptr + 10'h001;
			S_GLYPH_LO: ram_rd_addr = udc_addr; // RULE4
			S_GLYPH_HI: ram_rd_addr = udc_addr | 10'h001;
			default: ram_rd_addr = s.cptr;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Strip sequencer and pixel path
	always_comb begin
		n = s;
		n.hs_d = hs_lvl;
		n.vs_d = vs_lvl;
		hs_rise = hs_lvl && !s.hs_d;
		vs_rise = vs_lvl && !s.vs_d;
		line_start = hs_rise || (s.px == line_len - 11'h001); // RULE8
		n.px = line_start ? 11'h000 : s.px + 11'h001;
		boundary = (s.px == s.cell_next);
		load = 1'b0;
		go_line = 1'b0;

		unique case (s.st)
			S_IDLE: ;
			S_DESC_HI: n.st = S_DESC_LO;
			S_DESC_LO: begin
				n.dhi = ram_rd;
				n.st = S_DESC_DONE;
			end
			S_DESC_DONE: begin
				n.dlo = ram_rd;
				n.slice = 5'h00;
				n.acc = 7'h00;
				if (s.dhi[7]) begin
					n.left = 14'(h_eff); // RULE15 RULE18
				end else begin
					n.left = 14'(ram_rd) * (s.dhi[6] ? 14'h0001 : 14'(h_eff)); // RULE17
				end
				n.first = !s.inl;
				n.st = S_HOLD;
				go_line = s.inl;
			end
			S_HOLD: ;
			S_SLICE: begin
				// One slice step per cycle, finished well inside the margin
				if (s.acc >= 7'(h_eff)) begin
					n.acc = s.acc - 7'(h_eff);
					if (s.slice != osd_pkg::LAST_SLICE) begin
						n.slice = s.slice + 5'h01; // RULE2
					end
				end else begin
					n.st = S_CODE;
				end
			end
			S_CODE: n.st = S_CODE_WAIT; // RULE13
			S_CODE_WAIT: begin
				n.code = ram_rd;
				n.cptr = s.cptr + 10'h001;
				if (ram_rd == osd_pkg::END_OF_ROW_CODE) begin
					n.st = S_ROW_END; // RULE20
				end else if (s.dlo[0] && ram_rd >= osd_pkg::UDC_FIRST
					&& ram_rd <= osd_pkg::UDC_LAST) begin
					n.st = S_GLYPH_LO; // RULE1
				end else if ((ram_rd >= osd_pkg::ROM_FIRST && ram_rd <= osd_pkg::ROM_LAST)
					|| ram_rd >= osd_pkg::ROM_HIGH_FIRST) begin
					n.st = S_ROM;
				end else begin
					// Control codes take no cell; only colour picks are honoured
					if (ram_rd >= osd_pkg::COLOUR_FIRST && ram_rd <= osd_pkg::COLOUR_LAST) begin
						n.colour = {s.colour[3], ram_rd[2:0]};
					end
					n.st = S_CODE;
				end
			end
			S_ROM: begin
				n.glyph = ROM_BITS;
				n.st = S_CELL_WAIT;
			end
			S_GLYPH_LO: n.st = S_GLYPH_HI;
			S_GLYPH_HI: begin
				n.udc_lo = ram_rd;
				n.st = S_GLYPH_DONE;
			end
			S_GLYPH_DONE: begin
				n.glyph = {ram_rd[3:0], s.udc_lo}; // RULE4
				n.st = S_CELL_WAIT;
			end
			S_CELL_WAIT: begin
				if (boundary) begin
					load = 1'b1;
					n.showing = 1'b1;
					n.cell_next = s.cell_next + osd_pkg::GLYPH_W; // RULE2
					n.st = S_CODE;
				end
			end
			S_ROW_END: begin
				if (boundary) begin
					n.showing = 1'b0; // RULE20
					n.st = S_HOLD;
				end
			end
		endcase

		if (line_start && !(s.st inside {S_IDLE, S_DESC_HI, S_DESC_LO, S_DESC_DONE})) begin
			n.showing = 1'b0;
			n.cell_next = margin; // RULE9
			load = 1'b0;
			if (s.first) begin
				n.first = 1'b0;
				go_line = 1'b1;
			end else if (s.left <= 14'h0001) begin
				n.st = S_DESC_HI; // RULE16
				n.ptr = s.ptr + osd_pkg::DESC_BYTES;
				n.inl = 1'b1;
			end else begin
				n.left = s.left - 14'h0001; // RULE15
				n.acc = s.acc + osd_pkg::SLICES_PER_GLYPH;
				go_line = 1'b1;
			end
		end
		if (line_start && s.st == S_DESC_DONE) begin
			n.cell_next = margin;
		end
		if (go_line) begin
			n.st = n.dhi[7] ? S_SLICE : S_HOLD; // RULE11
			n.cptr = {n.dhi[1:0], n.dlo[7:1], 1'b0}; // RULE18
			n.colour = n.dhi[5:2];
		end
		if (vs_rise) begin
			n.st = S_DESC_HI; // RULE14
			n.ptr = osd_pkg::PAGE_STRIDE * 10'(s.cfg.page);
			n.inl = 1'b0;
			n.showing = 1'b0;
			load = 1'b0;
		end

		// Pixel path: bit 11 goes out first
		shape_now = load ? s.glyph : s.shape;
		n.shape = {shape_now[10:0], 1'b0}; // RULE5
		if (s.st == S_IDLE) begin
			n.col_out = 4'h0;
			n.fb = 1'b0;
		end else if (!s.dhi[7] || !s.dhi[6]) begin
			n.col_out = 4'h0; // RULE12 RULE19
			n.fb = s.cfg.blank_level_bit;
		end else if (n.showing) begin
			n.col_out = shape_now[11] ? s.colour : 4'h0; // RULE3
			n.fb = 1'b1;
		end else begin
			n.col_out = 4'h0;
			n.fb = 1'b0;
		end

		// APB: read data and error are captured in the setup cycle
		if (PSEL && !PENABLE) begin
			n.pslverr = 1'b0;
			n.prdata = 32'h0000_0000;
			if (!PADDR[osd_pkg::RAM_WIN_BIT]) begin
				unique case (PADDR)
					osd_pkg::OFF_CTRL: n.prdata = 32'({s.cfg.blank_level_bit, s.cfg.page});
					osd_pkg::OFF_LINE: n.prdata = 32'(s.cfg.line_length_setting);
					osd_pkg::OFF_DELAY: n.prdata = 32'(s.cfg.horizontal_delay_setting);
					osd_pkg::OFF_HEIGHT: n.prdata = 32'(s.cfg.glyph_height_lines);
					osd_pkg::OFF_STATUS: n.prdata = 32'({s.showing, s.slice, s.dhi[7], s.st});
					default: n.pslverr = 1'b1;
				endcase
			end
		end
		if (PSEL && PENABLE && PWRITE && !PADDR[osd_pkg::RAM_WIN_BIT]) begin
			unique case (PADDR)
				osd_pkg::OFF_CTRL: begin
					n.cfg.page = PWDATA[osd_pkg::CTRL_PAGE_MSB:osd_pkg::CTRL_PAGE_LSB];
					n.cfg.blank_level_bit = PWDATA[osd_pkg::CTRL_BLANK_BIT];
				end
				osd_pkg::OFF_LINE: n.cfg.line_length_setting = PWDATA[6:0];
				osd_pkg::OFF_DELAY: n.cfg.horizontal_delay_setting = PWDATA[7:0];
				osd_pkg::OFF_HEIGHT: n.cfg.glyph_height_lines = PWDATA[5:0];
				default: ;
			endcase
		end
		ram_wr.en = PSEL && PENABLE && PWRITE && PADDR[osd_pkg::RAM_WIN_BIT];
		ram_wr.addr = PADDR[11:2];
		ram_wr.data = PWDATA[7:0];
	end

	// Single pixel-clock domain; CE freezes everything
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			s <= '0; // RULE21 RULE22
			s.cfg <= '{osd_pkg::RST_PAGE, osd_pkg::RST_BLANK, osd_pkg::RST_LINE,
				osd_pkg::RST_DELAY, osd_pkg::RST_HEIGHT};
		end else if (CE) begin
			s <= n;
		end
	end

	assign PREADY = CE;
	assign PRDATA = s.prdata;
	assign PSLVERR = s.pslverr;
	assign ROM_CODE = s.code;
	assign ROM_SLICE = s.slice;
	assign COLOR = s.col_out;
	assign FAST_BLANK_OUTPUT = s.fb;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);

	property p_user_fetch;
		s.st == S_GLYPH_LO |-> s.dlo[0] && s.code >= 8'hf0 && s.code <= 8'hfe;
	endproperty
	a_user_fetch: assert property (p_user_fetch) else $error("user glyph from bad code"); // RULE1

	property p_slice_addr;
		s.st == S_GLYPH_LO |-> ram_rd_addr[9:6] == s.code[3:0]
			&& ram_rd_addr[5:0] == {s.slice + 5'h07, 1'b0};
	endproperty
	a_slice_addr: assert property (p_slice_addr) else $error("user slice address wrong"); // RULE6

	property p_cell_pixel;
		CE && s.st == S_CELL_WAIT && boundary && !line_start && !vs_rise && s.dhi[7:6] == 2'b11
			|=> COLOR == ($past(s.glyph[11]) ? $past(s.colour) : 4'h0) && FAST_BLANK_OUTPUT;
	endproperty
	a_cell_pixel: assert property (p_cell_pixel) else $error("first cell pixel wrong"); // RULE5

	property p_line_wrap;
		CE && s.px == line_len - 11'h001 |=> s.px == 11'h000;
	endproperty
	a_line_wrap: assert property (p_line_wrap) else $error("line length not kept"); // RULE8

	property p_margin;
		CE && line_start && s.st == S_HOLD && !vs_rise |=> s.cell_next == $past(margin)
			&& s.cell_next >= 11'd54;
	endproperty
	a_margin: assert property (p_margin) else $error("left margin wrong"); // RULE9

	property p_floor;
		s.cfg.horizontal_delay_setting <= 8'h07 |->
			margin == (s.cfg.horizontal_delay_setting[0] ? 11'd60 : 11'd54);
	endproperty
	a_floor: assert property (p_floor) else $error("margin floor wrong"); // RULE10

	property p_spacing;
		CE && s.st != S_IDLE && !s.dhi[7] |=> COLOR == 4'h0
			&& FAST_BLANK_OUTPUT == $past(s.cfg.blank_level_bit);
	endproperty
	a_spacing: assert property (p_spacing) else $error("spacing line output wrong"); // RULE12

	property p_hidden;
		CE && s.st != S_IDLE && s.dhi[7:6] == 2'b10 |=> COLOR == 4'h0
			&& FAST_BLANK_OUTPUT == $past(s.cfg.blank_level_bit);
	endproperty
	a_hidden: assert property (p_hidden) else $error("hidden strip output wrong"); // RULE19

	property p_vsync;
		CE && vs_rise |=> s.st == S_DESC_HI && ram_rd_addr == {$past(s.cfg.page), 6'h00};
	endproperty
	a_vsync: assert property (p_vsync) else $error("table restart wrong"); // RULE14

	property p_next_desc;
		CE && line_start && !vs_rise && s.st == S_HOLD && !s.first && s.left == 14'h0001
			|=> s.st == S_DESC_HI && s.ptr == $past(s.ptr) + 10'h002;
	endproperty
	a_next_desc: assert property (p_next_desc) else $error("next descriptor missed"); // RULE16

	property p_row_end;
		CE && s.st == S_ROW_END && !line_start && !vs_rise |=> s.st inside {S_ROW_END, S_HOLD};
	endproperty
	a_row_end: assert property (p_row_end) else $error("fetch after row end"); // RULE20

	property p_idle_quiet;
		s.st == S_IDLE && $past(s.st) == S_IDLE |-> COLOR == 4'h0 && !FAST_BLANK_OUTPUT;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle outputs active"); // RULE22

	c_user_glyph: cover property (s.st == S_GLYPH_DONE ##1 s.st == S_CELL_WAIT);
	c_row_end: cover property (s.st == S_ROW_END ##[1:200] s.st == S_HOLD);
	c_spacing: cover property (s.st == S_HOLD && !s.dhi[7] && FAST_BLANK_OUTPUT);
endmodule

// ### verification/glyph_store_model.sv
// Fixed glyph store standing behind the engine's lookup port.
// Assumes the engine samples the answer in the cycle after it registers code and slice.
`timescale 1ns/1ps
module glyph_store_model (
	input wire logic [7:0] code,
	input wire logic [4:0] slice,
	output logic [11:0] bits
);
	////////////////////////////////////////////////////////////////
	// Answer is combinational, a pattern the bench can predict.
	// Slices past the last one return the inverse, never a friendly copy.
	assign bits = (slice > 5'h11) ? ~{code[3:0], code} : {code[3:0], code};
endmodule

// ### verification/testbench.sv
// Self-checking bench for the strip display engine.
// Assumes APB register access and a glyph store model on the lookup port.
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic hsync = 1'b0;
	logic vsync = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [12:0] paddr = 13'h0000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] rom_code;
	logic [4:0] rom_slice;
	logic [11:0] rom_bits;
	logic [3:0] color;
	logic fbo;
	logic [31:0] rdata;
	logic rerr;
	logic [3:0] pix [12];
	int first_at;
	int shown_n;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;

	// Stands in for the pixel clock derived from the reference clock
	always #5 clk = ~clk;

	osd_engine dut (.CLK(clk), .NRST(nrst), .CE(1'b1), .HSYNC(hsync), .VSYNC(vsync),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ROM_CODE(rom_code),
		.ROM_SLICE(rom_slice), .ROM_BITS(rom_bits), .COLOR(color), .FAST_BLANK_OUTPUT(fbo));
	glyph_store_model store (.code(rom_code), .slice(rom_slice), .bits(rom_bits));

	////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Whole run is about 10000 cycles; a hang ends here
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic ram(input int n, input logic [7:0] d);
		apb(1'b1, 13'h1000 + 13'(4 * n), {24'h0, d});
	endtask

	////////////////////////////////////////////////////////////////
	// Frame sync, then one line sync that zeroes the pixel counter
	task automatic sync_pulses();
		@(posedge clk);
		vsync <= 1'b1;
		repeat (8) @(posedge clk);
		vsync <= 1'b0;
		repeat (30) @(posedge clk);
		hsync <= 1'b1;
		repeat (4) @(posedge clk);
		hsync <= 1'b0;
	endtask

	// Frame start, one line sync, then watch one line of pixels
	task automatic frame_line();
		sync_pulses();
		first_at = -1;
		shown_n = 0;
		for (int t = 0; t < 700; t++) begin
			@(posedge clk);
			#1;
			if (fbo === 1'b1) begin
				if (first_at < 0) first_at = t;
				if (shown_n < 12) pix[shown_n] = color;
				shown_n++;
			end
		end
	endtask

	task automatic reset_values();
		logic [12:0] a [4] = '{osd_pkg::OFF_CTRL, osd_pkg::OFF_LINE, osd_pkg::OFF_DELAY,
			osd_pkg::OFF_HEIGHT};
		logic [31:0] e [4] = '{32'h0, 32'h40, 32'h10, 32'h12};
		check({31'h0, fbo}, 32'h0);
		check({28'h0, color}, 32'h0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, a[i], 32'h0);
			check(rdata, e[i]);
		end
		apb(1'b1, 13'h0014, 32'hff);
		check({31'h0, rerr}, 32'h1);
		apb(1'b0, 13'h0014, 32'h0);
		check({rdata[30:0], rerr}, 32'h1);
		apb(1'b0, 13'h1000, 32'h0);
		check({rdata[30:0], rerr}, 32'h0);
		$display("done reset_values");
	endtask

	// Code 241 holds a5c in every slice, code 240 all ones
	task automatic load_ram();
		for (int s = 0; s < 18; s++) begin
			ram(64 + 2 * (s + 7), 8'h5c);
			ram(65 + 2 * (s + 7), 8'hfa);
			ram(2 * (s + 7), 8'hff);
			ram(1 + 2 * (s + 7), 8'hff);
		end
		ram(256, 8'hf1);
		ram(257, 8'h0f);
		ram(258, 8'hf1);
		// Tables sit in the unused heads of glyph areas
		for (int k = 0; k < 2; k++) begin
			ram(192 + 2 * k, 8'hd5);
		end
	endtask

	task automatic glyph_case(input logic user_glyph_enable);
		logic [11:0] bits;
		bits = user_glyph_enable ? 12'ha5c : 12'h1f1;
		ram(193, {7'h0, user_glyph_enable});
		ram(195, {7'h0, user_glyph_enable});
		apb(1'b1, osd_pkg::OFF_CTRL, 32'h3);
		frame_line();
		check(32'(shown_n), 32'd12);
		for (int i = 0; i < 12; i++) begin
			check({28'h0, pix[i]}, bits[11 - i] ? 32'h5 : 32'h0);
		end
		$display("done glyph_case %0d", user_glyph_enable);
	endtask

	task automatic margins();
		int d [5] = '{4, 6, 5, 7, 12};
		int m [5];
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, osd_pkg::OFF_DELAY, 32'(d[i]));
			frame_line();
			m[i] = first_at;
		end
		check(32'(m[1] - m[0]), 32'd0);
		check(32'(m[3] - m[2]), 32'd0);
		check(32'(m[3] - m[1]), 32'd6);
		check(32'(m[4] - m[1]), 32'd36);
		$display("done margins");
	endtask

	// Spacing and hidden strips, each with both blank levels
	task automatic blank_strips();
		int bad;
		for (int k = 0; k < 4; k++) begin
			ram(128, k[1] ? 8'h95 : 8'h40);
			ram(129, k[1] ? 8'h01 : 8'h05);
			apb(1'b1, osd_pkg::OFF_CTRL, 32'h2 | (32'(k[0]) << 4));
			frame_line();
			bad = 0;
			repeat (200) begin
				@(posedge clk);
				#1;
				if (fbo !== k[0] || color !== 4'h0) bad++;
			end
			check(32'(bad), 32'd0);
		end
		$display("done blank_strips");
	endtask

	// Two-line strips of short lines; after one line sync the counter wraps on its own
	task automatic line_period();
		int e [3] = '{-1, -1, -1};
		int k;
		logic prev;
		k = 0;
		prev = 1'b0;
		apb(1'b1, osd_pkg::OFF_CTRL, 32'h3);
		apb(1'b1, osd_pkg::OFF_LINE, 32'h10);
		apb(1'b1, osd_pkg::OFF_HEIGHT, 32'h2);
		sync_pulses();
		for (int t = 0; t < 1500 && k < 3; t++) begin
			@(posedge clk);
			#1;
			if (fbo === 1'b1 && !prev) begin
				e[k] = t;
				k++;
			end
			prev = (fbo === 1'b1);
		end
		check(32'(e[1] - e[0]), 32'(12 * (2 * (32'h10 >> 1) + 1)));
		check(32'(e[2] - e[1]), 32'(12 * (2 * (32'h10 >> 1) + 1)));
		$display("done line_period");
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		reset_values();
		load_ram();
		glyph_case(1'b1);
		glyph_case(1'b0);
		margins();
		blank_strips();
		line_period();
		print_verdict();
	end
endmodule
